// *** inc/swcmd_map.svh ***
// Purpose: constants of the single-wire command and write sequencer
// Assumes: 100 MHz ref_clk
// Notes: offsets, fields, resets and times only
`ifndef SWCMD_MAP_SVH
`define SWCMD_MAP_SVH
// ----------------------------------------
// opcodes, upper nibble of device address byte; lock memory address upper nibble
// ----------------------------------------
`define SWCMD_OP_MAIN 4'hA
`define SWCMD_OP_SEC 4'hB
`define SWCMD_OP_LOCK 4'h2
`define SWCMD_OP_ZONE 4'h7
`define SWCMD_OP_FREEZE 4'h1
`define SWCMD_OP_MFID 4'hC
`define SWCMD_OP_STD 4'hD
`define SWCMD_OP_HS 4'hE
`define SWCMD_LOCK_ADDR_HI 4'h6
// ----------------------------------------
// device address byte fields
// ----------------------------------------
`define SWCMD_OP_MSB 7
`define SWCMD_OP_LSB 4
`define SWCMD_SA_MSB 3
`define SWCMD_SA_LSB 1
`define SWCMD_RW_BIT 0
// ----------------------------------------
// organisation and reset values
// ----------------------------------------
`define SWCMD_MAIN_WORDS 128
`define SWCMD_SEC_WORDS 32
`define SWCMD_SEC_RO_WORDS 5'h10
`define SWCMD_PAGE_BYTES 8
`define SWCMD_ZONES 4
`define SWCMD_HS_RESET 1'b1
// ----------------------------------------
// times
// ----------------------------------------
`define SWCMD_CLK_MHZ 100
`define SWCMD_PROGRAM_CYCLE_TIME_US 1000
`define SWCMD_DISCHARGE_INTERRUPT_TIME_US 150
`endif

// *** inc/swcmd_pkg.sv ***
// Purpose: types of the single-wire command and write sequencer
// Assumes: nothing
// Notes: constants live in swcmd_map.svh
package swcmd_pkg;
  typedef enum logic [2:0] {
    SW_IDLE = 3'h0,
    SW_DEV = 3'h1,
    SW_MADDR = 3'h2,
    SW_DATA = 3'h3,
    SW_SKIP = 3'h4,
    SW_PROG = 3'h5
  } swcmd_state_t;
  typedef enum logic [2:0] {
    K_MAIN = 3'h0,
    K_SEC = 3'h1,
    K_LOCK = 3'h2,
    K_ZONE = 3'h3,
    K_FREEZE = 3'h4
  } swcmd_kind_t;
endpackage

// *** src/swcmd_fifo.sv ***
// Purpose: write-data buffer between byte receiver and programming
// Assumes: one clock, flush discards contents
// Notes: full and empty from pointers with a wrap bit
`timescale 1ns/1ps
module swcmd_fifo #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = $clog2(D)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data = mem[rp_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end else begin
      if (push) begin
        wp_nxt = wp_r + (AW+1)'(1);
      end
      if (pop) begin
        rp_nxt = rp_r + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push && !flush) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// *** src/swcmd_core.sv ***
// Purpose: command decode and write sequencing of a single-wire memory
// Assumes: a bit-frame layer on ref_clk delivers input symbols and sends responses
// Notes: reads, id data and bit timing live outside this block
`timescale 1ns/1ps
`include "swcmd_map.svh"

// Operation
// - main array is sixteen pages of eight bytes, 7-bit word address
// - security area four pages; low two read-only with the serial in the lowest, upper two writable until locked
// - opcode 1010 accesses the main array
// - opcode 1011 accesses the security area
// - opcode 0010 permanently locks the writable security pages
// - four main zones, each may become read-only via opcode 0111
// - opcode 0001 freezes zone configuration for good
// - opcode 1100 is the identification query
// - 1101 standard speed, 1110 high speed; high speed after reset
// - stop off a data byte boundary aborts the write unprogrammed
// - commands ignored while programming; short low pulse answered with NACK
// - long low during programming ends the cycle; only written bytes suffer
// - ACK device address, memory address and each data byte
// - stop after data starts a self-timed cycle of bounded length
// - page write of up to eight bytes within one row
// - up to seven more bytes acknowledged; programming starts at the stop
// - only low three address bits advance, wrapping inside the page
// - memory address bit 7 ignored for the main array
// - address byte: opcode 7..4, slave address 3..1, read bit 0
// - bad opcode or other slave address: no drive, back to standby
// - start and stop are the same held-high condition
module swcmd_core #(
  parameter logic [2:0] SLAVE_ADDR = 3'h0,
  // arbitrary serial value
  parameter logic [63:0] SERIAL = 64'h0123456789ABCDEF,
  parameter int PROG_CYCLES = `SWCMD_PROGRAM_CYCLE_TIME_US * `SWCMD_CLK_MHZ,
  parameter int DSCHG_CYCLES = `SWCMD_DISCHARGE_INTERRUPT_TIME_US * `SWCMD_CLK_MHZ,
  parameter int FIFO_DEPTH = `SWCMD_PAGE_BYTES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // symbols from the bit-frame layer
  input wire logic sym_valid,
  input wire logic sym_bit,
  input wire logic sym_stop,
  // raw line state, high while pulled down
  input wire logic line_low,
  // response for the next output frame
  output logic resp_valid,
  output logic resp_ack,
  // state
  output logic busy,
  output logic hs_mode,
  output logic sec_locked,
  output logic [3:0] zone_rom,
  output logic zone_frozen,
  // debug read port
  input wire logic rd_sec,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  swcmd_pkg::swcmd_state_t st_r, st_nxt;
  swcmd_pkg::swcmd_kind_t kind_r, kind_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [6:0] shift_r, shift_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic got_r, got_nxt;
  logic [31:0] prog_cnt_r, prog_cnt_nxt;
  logic [31:0] low_cnt_r, low_cnt_nxt;
  logic resp_valid_r, resp_valid_nxt, resp_ack_r, resp_ack_nxt;
  logic hs_r, hs_nxt, lock_r, lock_nxt, frz_r, frz_nxt;
  logic [3:0] zone_r, zone_nxt;
  logic zset_r, zset_nxt;
  logic line_s1_r, line_s2_r;
  logic [7:0] main_mem [`SWCMD_MAIN_WORDS];
  logic [7:0] sec_mem [`SWCMD_SEC_WORDS];
  logic [7:0] rd_data_r;
  logic [7:0] byte_in;
  logic byte_done, op_ok, flush, push, in_ready, out_valid, out_ready, drain;
  logic [15:0] out_data;
  logic [3:0] op;
  logic prog_end, dschg;
  logic busy_r, busy_nxt;

  assign byte_in = {shift_r, sym_bit};
  assign byte_done = sym_valid && !sym_stop && (bit_cnt_r == 3'h7);
  assign op = byte_in[`SWCMD_OP_MSB:`SWCMD_OP_LSB];
  assign prog_end = (prog_cnt_r == 32'(PROG_CYCLES - 1));
  assign dschg = line_s2_r && (low_cnt_r >= 32'(DSCHG_CYCLES - 1));

  always_comb begin
    case (op)
      `SWCMD_OP_MAIN, `SWCMD_OP_SEC, `SWCMD_OP_LOCK, `SWCMD_OP_ZONE,
      `SWCMD_OP_FREEZE, `SWCMD_OP_MFID, `SWCMD_OP_STD, `SWCMD_OP_HS: op_ok = 1'b1;
      default: op_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    got_nxt = got_r;
    prog_cnt_nxt = prog_cnt_r;
    low_cnt_nxt = line_s2_r ? low_cnt_r + 32'h1 : 32'h0;
    resp_valid_nxt = 1'b0;
    resp_ack_nxt = resp_ack_r;
    hs_nxt = hs_r;
    lock_nxt = lock_r;
    frz_nxt = frz_r;
    zone_nxt = zone_r;
    zset_nxt = zset_r;
    flush = 1'b0;
    push = 1'b0;
    if (st_r != swcmd_pkg::SW_PROG && sym_valid && !sym_stop) begin
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      shift_nxt = byte_in[6:0];
    end
    if (st_r != swcmd_pkg::SW_PROG && sym_stop) begin
      bit_cnt_nxt = 3'h0;
      st_nxt = swcmd_pkg::SW_DEV;
      flush = 1'b1;
    end
    case (st_r)
      swcmd_pkg::SW_IDLE: begin
        bit_cnt_nxt = 3'h0;
      end
      swcmd_pkg::SW_DEV: begin
        if (byte_done) begin
          resp_valid_nxt = 1'b1;
          resp_ack_nxt = 1'b1;
          st_nxt = swcmd_pkg::SW_SKIP;
          if (!op_ok || byte_in[`SWCMD_SA_MSB:`SWCMD_SA_LSB] != SLAVE_ADDR) begin
            resp_valid_nxt = 1'b0;
            st_nxt = swcmd_pkg::SW_IDLE;
          end else if (op == `SWCMD_OP_STD || op == `SWCMD_OP_HS) begin
            if (byte_in[`SWCMD_RW_BIT]) begin
              resp_ack_nxt = (op == `SWCMD_OP_HS) ? hs_r : !hs_r;
            end else begin
              hs_nxt = (op == `SWCMD_OP_HS);
            end
          end else if (!byte_in[`SWCMD_RW_BIT] && op != `SWCMD_OP_MFID) begin
            st_nxt = swcmd_pkg::SW_MADDR;
            case (op)
              `SWCMD_OP_MAIN: kind_nxt = swcmd_pkg::K_MAIN;
              `SWCMD_OP_SEC: kind_nxt = swcmd_pkg::K_SEC;
              `SWCMD_OP_LOCK: kind_nxt = swcmd_pkg::K_LOCK;
              `SWCMD_OP_ZONE: kind_nxt = swcmd_pkg::K_ZONE;
              default: kind_nxt = swcmd_pkg::K_FREEZE;
            endcase
          end
        end
      end
      swcmd_pkg::SW_MADDR: begin
        if (byte_done) begin
          resp_valid_nxt = 1'b1;
          resp_ack_nxt = 1'b1;
          addr_nxt = byte_in;
          got_nxt = 1'b0;
          st_nxt = swcmd_pkg::SW_DATA;
          if (kind_r == swcmd_pkg::K_LOCK && (lock_r || byte_in[7:4] != `SWCMD_LOCK_ADDR_HI)) begin
            resp_ack_nxt = 1'b0;
            st_nxt = swcmd_pkg::SW_IDLE;
          end
        end
      end
      swcmd_pkg::SW_DATA: begin
        if (byte_done) begin
          resp_valid_nxt = 1'b1;
          resp_ack_nxt = 1'b1;
          if ((kind_r == swcmd_pkg::K_SEC || kind_r == swcmd_pkg::K_LOCK) && lock_r
              || (kind_r == swcmd_pkg::K_ZONE || kind_r == swcmd_pkg::K_FREEZE) && frz_r) begin
            resp_ack_nxt = 1'b0;
            st_nxt = swcmd_pkg::SW_IDLE;
            flush = 1'b1;
          end else if (kind_r == swcmd_pkg::K_ZONE) begin
            zset_nxt = (byte_in != 8'h00);
            got_nxt = 1'b1;
          end else if (kind_r == swcmd_pkg::K_MAIN || kind_r == swcmd_pkg::K_SEC) begin
            // byte queued and acknowledged while room
            if (in_ready) begin
              push = 1'b1;
              got_nxt = 1'b1;
              addr_nxt = {addr_r[7:3], addr_r[2:0] + 3'h1};
            end else begin
              resp_ack_nxt = 1'b0;
            end
          end else begin
            got_nxt = 1'b1;
          end
        end
        if (sym_stop) begin
          // program only on a byte boundary
          if (bit_cnt_r == 3'h0 && got_r) begin
            st_nxt = swcmd_pkg::SW_PROG;
            prog_cnt_nxt = 32'h0;
            flush = 1'b0;
          end
        end
      end
      swcmd_pkg::SW_SKIP: begin
        bit_cnt_nxt = bit_cnt_nxt;
      end
      swcmd_pkg::SW_PROG: begin
        prog_cnt_nxt = prog_cnt_r + 32'h1;
        if (sym_valid && !sym_stop) begin
          resp_valid_nxt = 1'b1;
          resp_ack_nxt = 1'b0;
        end
        if (dschg) begin
          st_nxt = swcmd_pkg::SW_IDLE;
          flush = 1'b1;
        end else if (prog_end) begin
          st_nxt = swcmd_pkg::SW_IDLE;
          case (kind_r)
            swcmd_pkg::K_LOCK: lock_nxt = 1'b1;
            swcmd_pkg::K_FREEZE: frz_nxt = 1'b1;
            swcmd_pkg::K_ZONE: zone_nxt[addr_r[1:0]] = zone_r[addr_r[1:0]] | zset_r;
            default: lock_nxt = lock_r;
          endcase
        end
      end
      default: st_nxt = swcmd_pkg::SW_IDLE;
    endcase
    // busy straight from a flop, same timing as the state
    busy_nxt = (st_nxt == swcmd_pkg::SW_PROG);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= swcmd_pkg::SW_IDLE;
      kind_r <= swcmd_pkg::K_MAIN;
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
      addr_r <= 8'h00;
      got_r <= 1'b0;
      prog_cnt_r <= 32'h0;
      low_cnt_r <= 32'h0;
      resp_valid_r <= 1'b0;
      resp_ack_r <= 1'b0;
      hs_r <= `SWCMD_HS_RESET;
      lock_r <= 1'b0;
      frz_r <= 1'b0;
      zone_r <= 4'h0;
      zset_r <= 1'b0;
      busy_r <= 1'b0;
      line_s1_r <= 1'b0;
      line_s2_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      got_r <= got_nxt;
      prog_cnt_r <= prog_cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_ack_r <= resp_ack_nxt;
      hs_r <= hs_nxt;
      lock_r <= lock_nxt;
      frz_r <= frz_nxt;
      zone_r <= zone_nxt;
      zset_r <= zset_nxt;
      busy_r <= busy_nxt;
      line_s1_r <= line_low;
      line_s2_r <= line_s1_r;
    end
  end

  // ----------------------------------------
  // page data buffer
  // ----------------------------------------
  // one byte per cycle; bit 7 dropped
  swcmd_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .flush(flush),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data({kind_r == swcmd_pkg::K_SEC, addr_r[6:0], byte_in}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
  assign out_ready = (st_r == swcmd_pkg::SW_PROG) && !dschg;
  assign drain = out_valid && out_ready;

  // ----------------------------------------
  // nonvolatile arrays
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `SWCMD_MAIN_WORDS; i++) begin
        main_mem[i] <= 8'h00;
      end
      for (int i = 0; i < `SWCMD_SEC_WORDS; i++) begin
        sec_mem[i] <= (i < 8) ? SERIAL[8*i +: 8] : 8'h00;
      end
      rd_data_r <= 8'h00;
    end else begin
      if (drain && out_data[15] && !lock_r && out_data[12:8] >= `SWCMD_SEC_RO_WORDS) begin
        sec_mem[out_data[12:8]] <= out_data[7:0];
      end
      if (drain && !out_data[15] && !zone_r[out_data[14:13]]) begin
        main_mem[out_data[14:8]] <= out_data[7:0];
      end
      rd_data_r <= rd_sec ? sec_mem[rd_addr[4:0]] : main_mem[rd_addr];
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_ack = resp_ack_r;
  assign busy = busy_r;
  assign hs_mode = hs_r;
  assign sec_locked = lock_r;
  assign zone_rom = zone_r;
  assign zone_frozen = frz_r;
  assign rd_data = rd_data_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_busy_nack:
    assert property (st_r == swcmd_pkg::SW_PROG && sym_valid && !sym_stop |=> resp_valid && !resp_ack)
    else $error("busy frame not nacked");
  a_prog_length:
    assert property (prog_cnt_r >= 32'(PROG_CYCLES) |-> st_r != swcmd_pkg::SW_PROG)
    else $error("program cycle overran");
  a_stop_abort:
    assert property (st_r == swcmd_pkg::SW_DATA && sym_stop && bit_cnt_r != 3'h0
      |=> st_r == swcmd_pkg::SW_DEV && !out_valid)
    else $error("misplaced stop did not abort");
  a_bad_silent:
    assert property (st_r == swcmd_pkg::SW_DEV && byte_done && !op_ok
      |=> !resp_valid && st_r == swcmd_pkg::SW_IDLE)
    else $error("bad opcode answered");
  a_addr_ack:
    assert property (st_r == swcmd_pkg::SW_MADDR && byte_done && kind_r == swcmd_pkg::K_MAIN
      |=> resp_valid && resp_ack ##1 !resp_valid)
    else $error("memory address not acked");
  a_page_wrap:
    assert property (push |=> addr_r[7:3] == $past(addr_r[7:3]) && addr_r[2:0] == $past(addr_r[2:0]) + 3'h1)
    else $error("address advance wrong");
  a_serial_kept:
    assert property (drain && out_data[15] && out_data[12:8] < `SWCMD_SEC_RO_WORDS
      |=> sec_mem[$past(out_data[12:8])] == $past(sec_mem[out_data[12:8]]))
    else $error("serial page altered");
  a_dschg_stop:
    assert property (st_r == swcmd_pkg::SW_PROG && dschg |=> st_r == swcmd_pkg::SW_IDLE && !out_valid)
    else $error("discharge did not end cycle");
  a_hs_select:
    assert property (st_r == swcmd_pkg::SW_DEV && byte_done && op_ok && op == `SWCMD_OP_STD
      && byte_in[3:1] == SLAVE_ADDR && !byte_in[0] |=> !hs_mode)
    else $error("standard speed not selected");
endmodule

// *** verification/swcmd_master.sv ***
// Purpose: bus master model feeding the symbol stream of swcmd_core
// Assumes: one symbol per ref_clk edge, stop is a one-cycle pulse
// Notes: idle data bit shows the inverse of the last bit sent
`timescale 1ns/1ps
module swcmd_master (
  // clock
  input wire logic ref_clk,
  // symbol stream to the device
  output logic sym_valid,
  output logic sym_bit,
  output logic sym_stop,
  output logic line_low
);
  initial begin
    sym_valid = 1'b0;
    sym_bit = 1'b0;
    sym_stop = 1'b0;
    line_low = 1'b0;
  end
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      sym_valid <= 1'b1;
      sym_bit <= b[7-i];
    end
    @(posedge ref_clk);
    sym_valid <= 1'b0;
    sym_bit <= ~b[8-n];
  endtask
  // stop is a null frame, no drive
  task automatic send_stop();
    @(posedge ref_clk);
    sym_stop <= 1'b1;
    @(posedge ref_clk);
    sym_stop <= 1'b0;
  endtask
  task automatic hold_low(input int n);
    @(posedge ref_clk);
    line_low <= 1'b1;
    repeat (n) @(posedge ref_clk);
    line_low <= 1'b0;
  endtask
endmodule

// *** verification/tb_top.sv ***
// Purpose: self-checking bench of swcmd_core
// Assumes: shortened program and discharge counts
// Notes: contents checked through the debug read port
`timescale 1ns/1ps
`include "swcmd_map.svh"
module tb_top;
  localparam logic [2:0] SA = 3'h5;
  // arbitrary serial value
  localparam logic [63:0] SER = 64'h5A3C0F1E9B27C468;
  localparam int PROG = 50;
  localparam int DSCHG = 10;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic sym_valid, sym_bit, sym_stop, line_low;
  logic resp_valid, resp_ack, busy, hs_mode, sec_locked, zone_frozen;
  logic [3:0] zone_rom;
  logic rd_sec = 1'b0;
  logic [6:0] rd_addr = 7'h00;
  logic [7:0] rd_data;
  logic [7:0] mem [128];
  logic [7:0] sec [32];
  logic [3:0] zr = 4'h0;
  logic lk = 1'b0;
  logic fz = 1'b0;
  logic [31:0] seed = 32'h33CE;
  logic rq [$];
  logic [3:0] bad_ops [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hF};
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (resp_valid === 1'b1) rq.push_back(resp_ack);
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end

  swcmd_core #(.SLAVE_ADDR(SA), .SERIAL(SER), .PROG_CYCLES(PROG), .DSCHG_CYCLES(DSCHG), .FIFO_DEPTH(8)) swcmd_core_i (
    .ref_clk(ref_clk), .nrst(nrst), .sym_valid(sym_valid), .sym_bit(sym_bit), .sym_stop(sym_stop),
    .line_low(line_low), .resp_valid(resp_valid), .resp_ack(resp_ack), .busy(busy), .hs_mode(hs_mode),
    .sec_locked(sec_locked), .zone_rom(zone_rom), .zone_frozen(zone_frozen), .rd_sec(rd_sec),
    .rd_addr(rd_addr), .rd_data(rd_data));
  swcmd_master swcmd_master_i (.ref_clk(ref_clk), .sym_valid(sym_valid), .sym_bit(sym_bit),
    .sym_stop(sym_stop), .line_low(line_low));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [7:0] rnd();
    seed = xs(seed);
    return seed[7:0];
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // exp: -1 no answer, 0 nack, 1 ack, 2 not looked at
  task automatic byte_chk(input logic [7:0] b, input int exp);
    rq.delete();
    swcmd_master_i.send_bits(b, 8);
    repeat (3) @(posedge ref_clk);
    if (exp < 0) chk("no_resp", rq.size(), 0);
    else if (exp < 2) begin
      chk("n_resp", rq.size(), 1);
      chk("ack", rq.size() > 0 ? rq[0] : 1'bx, exp[0]);
    end
  endtask
  task automatic dev(input logic [3:0] op, input logic [2:0] sa, input logic rw, input int exp);
    swcmd_master_i.send_stop();
    byte_chk({op, sa, rw}, exp);
  endtask
  task automatic quiet_stop();
    swcmd_master_i.send_stop();
    repeat (3) @(posedge ref_clk);
    chk("no_prog", busy, 0);
  endtask
  // mode 0 plain, 1 poke while busy, 2 discharge
  task automatic wr(input logic [3:0] op, input logic [7:0] ma, input int n, input int dack, input int mode);
    logic [7:0] d [9];
    logic [6:0] a;
    int w;
    int t0;
    dev(op, SA, 1'b0, 1);
    byte_chk(ma, 1);
    for (int i = 0; i < n; i++) begin
      d[i] = rnd();
      byte_chk(d[i], i < 8 ? dack : 0);
    end
    swcmd_master_i.send_stop();
    t0 = cyc;
    repeat (2) @(posedge ref_clk);
    chk("busy_start", busy, 1);
    if (mode == 1) begin
      rq.delete();
      swcmd_master_i.send_bits(rnd(), 8);
      swcmd_master_i.send_stop();
      repeat (2) @(posedge ref_clk);
      chk("busy_n", rq.size(), 8);
      chk("busy_nack", rq.or(), 0);
      chk("still_busy", busy, 1);
    end
    if (mode == 2) begin
      swcmd_master_i.hold_low(DSCHG + 4);
      repeat (3) @(posedge ref_clk);
      chk("dschg_end", busy, 0);
      return;
    end
    w = 0;
    while (busy === 1'b1 && w < 1000) begin
      @(posedge ref_clk);
      w++;
    end
    // busy seen from the edge after the stop up to the edge after it drops
    chk("busy_len", cyc - t0, PROG + 1);
    for (int i = 0; i < n && i < 8; i++) begin
      a = {ma[6:3], ma[2:0] + 3'(i)};
      if (op == `SWCMD_OP_MAIN && !zr[a[6:5]]) mem[a] = d[i];
      if (op == `SWCMD_OP_SEC && a[4] && !lk) sec[a[4:0]] = d[i];
    end
    if (op == `SWCMD_OP_LOCK) lk = 1'b1;
    if (op == `SWCMD_OP_ZONE && d[0] != 8'h00 && !fz) zr[ma[1:0]] = 1'b1;
    if (op == `SWCMD_OP_FREEZE) fz = 1'b1;
  endtask
  task automatic verify(input string name);
    for (int i = 0; i < 160; i++) begin
      @(posedge ref_clk);
      rd_sec <= (i >= 128);
      rd_addr <= 7'(i % 128);
      @(posedge ref_clk);
      @(posedge ref_clk);
      #1;
      chk("rd_data", rd_data, i < 128 ? mem[i] : sec[i-128]);
    end
    chk("locked", sec_locked, lk);
    chk("zone_rom", zone_rom, zr);
    chk("frozen", zone_frozen, fz);
    $display("test %s done", name);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    for (int i = 0; i < 32; i++) sec[i] = i < 8 ? SER[8*i +: 8] : 8'h00;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk("busy_rst", busy, 0);
    chk("hs_rst", hs_mode, 1);
    verify("reset");
    // counts of at most eight never overrun a page
    for (int k = 0; k < 8; k++) wr(`SWCMD_OP_MAIN, rnd(), 1 + rnd() % 8, 1, 0);
    wr(`SWCMD_OP_MAIN, 8'h38, 9, 1, 0);
    wr(`SWCMD_OP_MAIN, 8'h91, 2, 1, 1);
    verify("page_write");
    wr(`SWCMD_OP_MAIN, 8'h22, 1, 1, 2);
    wr(`SWCMD_OP_MAIN, 8'h22, 1, 1, 0);
    dev(`SWCMD_OP_MAIN, SA, 1'b0, 1);
    byte_chk(8'h40, 1);
    swcmd_master_i.send_bits(rnd(), 4);
    quiet_stop();
    dev(`SWCMD_OP_MAIN, SA, 1'b0, 1);
    byte_chk(8'h41, 1);
    quiet_stop();
    verify("abort");
    foreach (bad_ops[j]) dev(bad_ops[j], SA, 1'b0, -1);
    dev(`SWCMD_OP_MAIN, SA ^ 3'h1, 1'b0, -1);
    byte_chk({`SWCMD_OP_MAIN, SA, 1'b0}, -1);
    $display("test refuse done");
    wr(`SWCMD_OP_SEC, 8'h03, 2, 2, 0);
    wr(`SWCMD_OP_SEC, 8'h15, 3, 1, 0);
    wr(`SWCMD_OP_LOCK, 8'h63, 1, 1, 0);
    dev(`SWCMD_OP_SEC, SA, 1'b0, 1);
    byte_chk(8'h10, 1);
    byte_chk(rnd(), 0);
    dev(`SWCMD_OP_LOCK, SA, 1'b0, 1);
    byte_chk(8'h60, 0);
    verify("security");
    wr(`SWCMD_OP_ZONE, 8'h01, 1, 1, 0);
    wr(`SWCMD_OP_MAIN, 8'h25, 2, 2, 0);
    wr(`SWCMD_OP_FREEZE, 8'h00, 1, 1, 0);
    dev(`SWCMD_OP_ZONE, SA, 1'b0, 1);
    byte_chk(8'h02, 1);
    byte_chk(8'h01, 0);
    verify("zones");
    dev(`SWCMD_OP_STD, SA, 1'b0, 1);
    dev(`SWCMD_OP_HS, SA, 1'b1, 0);
    chk("hs_std", hs_mode, 0);
    dev(`SWCMD_OP_STD, SA, 1'b1, 1);
    dev(`SWCMD_OP_HS, SA, 1'b0, 1);
    dev(`SWCMD_OP_HS, SA, 1'b1, 1);
    chk("hs_back", hs_mode, 1);
    dev(`SWCMD_OP_MFID, SA, 1'b1, 1);
    dev(`SWCMD_OP_MAIN, SA, 1'b1, 1);
    $display("test speed done");
    final_report();
  end
endmodule
